// [mpdp_pkg.sv]
package mpdp_pkg;

  // I/O port of the page register and the control port
  localparam logic [7:0] MPDP_PORT_PAGE = 8'h05;
  localparam logic [7:0] MPDP_PORT_CTRL = 8'h0E;
  // Control port bit positions
  localparam int MPDP_CTRL_ROM_BIT = 0;
  localparam int MPDP_CTRL_LINK_BIT = 1;
  localparam int MPDP_CTRL_CS128_BIT = 2;
  localparam int MPDP_CTRL_BADPAR_BIT = 3;
  // Reset values
  localparam logic [1:0] MPDP_PAGE_RST = 2'h0;
  localparam logic MPDP_ROM_RST = 1'b1;
  localparam logic MPDP_LINK_RST = 1'b0;
  // Parity error jump address seen by the processor
  localparam logic [15:0] MPDP_NMI_VECTOR = 16'h0066;
  // Strobe sequence timing in ns, rounded up to whole clock cycles
  localparam int MPDP_ROW_NS = 16;
  localparam int MPDP_COL_NS = 24;
  localparam int MPDP_CLK_NS = 8;
  localparam logic [3:0] MPDP_ROW_CYC = 4'((MPDP_ROW_NS + MPDP_CLK_NS - 1) / MPDP_CLK_NS);
  localparam logic [3:0] MPDP_COL_CYC = 4'((MPDP_COL_NS + MPDP_CLK_NS - 1) / MPDP_CLK_NS);

  // Block enables from the decoder
  typedef struct packed {
    logic main_ram;
    logic diag_rom;
    logic char_ram;
    logic attr_ram;
    logic font_lo;
    logic font_hi;
  } mpdp_sel_t;

  // One memory request from either master
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic mreq;
    logic rd;
    logic wr;
    logic fetch;
    logic rfsh;
  } mpdp_req_t;

  // DRAM pin group
  typedef struct packed {
    logic [7:0] addr;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [8:0] dq_out;
    logic dq_oe;
  } mpdp_dram_t;

  // Even parity bit: makes total ones across nine bits even
  function automatic logic mpdp_parity(input logic [7:0] d);
    return ^d;
  endfunction

endpackage

// [mpdp_decode.sv]
`timescale 1ns/1ps
module mpdp_decode (
  input wire mpdp_pkg::mpdp_req_t req,
  input wire logic [1:0] page,
  input wire logic rom_sel,
  input wire logic small_charset_select,
  input wire logic reduced_mem,
  output mpdp_pkg::mpdp_sel_t sel
);
  import mpdp_pkg::*;
  logic [4:0] bus_addr_upper_bits;
  logic page_sel_low;
  logic page_sel_high;
  logic valid;
  logic low4k;

  // Block memory decode from page, control bits and top address bits
  always_comb begin
    bus_addr_upper_bits = req.addr[15:11];
    page_sel_low = page[0];
    page_sel_high = page[1];
    valid = req.mreq && !req.rfsh;
    low4k = bus_addr_upper_bits[4:1] == 4'h0;
    sel = '0;
    if (valid) begin
      sel.diag_rom = rom_sel && low4k && !req.wr;
      sel.char_ram = !page_sel_high && !page_sel_low && bus_addr_upper_bits[4:2] == 3'h7;
      sel.attr_ram = !page_sel_high && !page_sel_low && bus_addr_upper_bits[4:2] == 3'h6;
      sel.font_lo = page_sel_high && !page_sel_low && bus_addr_upper_bits[4:1] == 4'hC
        && !(small_charset_select && bus_addr_upper_bits[0]);
      sel.font_hi = page_sel_high && !page_sel_low && bus_addr_upper_bits[4:1] == 4'hD
        && !(small_charset_select && bus_addr_upper_bits[0]);
      if (low4k) begin
        sel.main_ram = !rom_sel;
      end else if (bus_addr_upper_bits[4:3] != 2'h3) begin
        sel.main_ram = 1'b1;
      end else begin
        sel.main_ram = page_sel_low;
      end
      if (reduced_mem && req.addr[15]) begin
        sel.main_ram = 1'b0;
      end
    end
  end
endmodule // mpdp_decode

// [mpdp_dram_seq.sv]
`timescale 1ns/1ps
module mpdp_dram_seq (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic refresh,
  input wire logic [15:0] addr,
  output logic [7:0] dram_addr,
  output logic ras_n,
  output logic cas_n,
  output logic col_phase,
  output logic done
);
  import mpdp_pkg::*;
  typedef enum logic [1:0] {S_IDLE, S_ROW, S_COL} mpdp_seq_state_t;
  typedef struct packed {
    mpdp_seq_state_t st;
    logic [3:0] cnt;
    logic [15:0] addr;
    logic rfsh;
    logic done;
  } mpdp_seq_t;
  mpdp_seq_t s_reg, s_next;

  // Row then column strobe sequence, row only for refresh
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    unique case (s_reg.st)
      S_IDLE: begin
        if (start) begin
          s_next.st = S_ROW;
          s_next.addr = addr;
          s_next.rfsh = refresh;
          s_next.cnt = MPDP_ROW_CYC;
        end
      end
      S_ROW: begin
        if (s_reg.cnt > 4'h1) begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end else if (s_reg.rfsh) begin
          s_next.st = S_IDLE;
          s_next.done = 1'b1;
        end else begin
          s_next.st = S_COL;
          s_next.cnt = MPDP_COL_CYC;
        end
      end
      S_COL: begin
        if (s_reg.cnt > 4'h1) begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end else begin
          s_next.st = S_IDLE;
          s_next.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: S_IDLE, cnt: 4'h0, addr: 16'h0000, rfsh: 1'b0, done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Shared address pins: high half with row strobe, low half with column strobe
  assign dram_addr = (s_reg.st == S_COL) ? s_reg.addr[7:0] : s_reg.addr[15:8];
  assign ras_n = !(s_reg.st == S_ROW || s_reg.st == S_COL);
  assign cas_n = !(s_reg.st == S_COL);
  assign col_phase = s_reg.st == S_COL;
  assign done = s_reg.done;
endmodule // mpdp_dram_seq

// [mpdp_top.sv]
`timescale 1ns/1ps
// Contract
// - Main memory stores nine bits per byte: eight data plus parity.
// - DRAM address goes out as row half then column half on shared pins.
// - Every main memory access, refresh included, runs a strobe cycle.
// - Processor and DMA link both reach main RAM through one path.
// - Processor writes store an even parity bit with the byte.
// - Processor read parity mismatch enables diagnostic ROM and raises NMI.
// - NMI comes only from a main memory parity error.
// - A forced bad-parity write read back must flag an error.
// - Output to port 05 latches data bits 0 and 1 into page register.
// - Decoder enables at most one memory for each page and address.
// - Page 0, top bits 111 selects character RAM.
// - Page 0, top bits 110 selects attribute RAM.
// - Page 2, 48K-52K selects lower font; small charset limits to 48K-50K.
// - Page 2, 52K-56K selects upper font; small charset limits to 52K-54K.
// - Small charset suppresses cycles to upper 2k of each font memory.
// - Main RAM at 4K-48K on every page (4K-32K with reduced memory), and 0K-4K when ROM not selected.
// - Main RAM at 48K-64K only when page low bit is one.
// - ROM selected: reads of lowest 4k come from diagnostic ROM.
// - ROM selected: writes to lowest 4k are blocked.
// - Reduced-memory option inhibits main RAM above 32k.
// - Enables only during valid memory request cycles.
// - Power-up selects ROM, link disabled; after tests ROM off, link on.
module mpdp_top #(
  parameter bit REDUCED_MEM = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire mpdp_pkg::mpdp_req_t cpu_req,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire mpdp_pkg::mpdp_req_t dma_req,
  input wire logic dma_active,
  input wire logic [8:0] dram_dq_in,
  output mpdp_pkg::mpdp_dram_t dram,
  output mpdp_pkg::mpdp_sel_t mem_sel,
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic nmi,
  output logic link_enable,
  output logic [1:0] page_out,
  output logic small_charset_select,
  output logic diag_rom_select
);
  import mpdp_pkg::*;

  typedef struct packed {
    logic [1:0] page;
    logic rom;
    logic link;
    logic cs128;
    logic badpar;
    logic busy;
    logic is_wr;
    logic is_rd_cpu;
    logic is_rfsh;
    logic nmi;
    logic [7:0] rdata;
    logic rvalid;
    mpdp_sel_t sel;
    mpdp_dram_t dram;
  } mpdp_state_t;
  mpdp_state_t s_reg, s_next;

  mpdp_req_t req;
  mpdp_sel_t sel_now;
  logic start;
  logic [7:0] seq_addr;
  logic seq_ras_n;
  logic seq_cas_n;
  logic seq_col;
  logic seq_done;
  logic rd_err;

  // Master select: DMA owns the path while it holds the bus and the link is enabled
  always_comb begin
    req = dma_active && s_reg.link ? dma_req : cpu_req;
  end

  mpdp_decode u_decode (
    .req(req),
    .page(s_reg.page),
    .rom_sel(s_reg.rom || s_reg.nmi),
    .small_charset_select(s_reg.cs128),
    .reduced_mem(REDUCED_MEM),
    .sel(sel_now)
  );

  // Start a strobe cycle for main RAM accesses and refresh
  assign start = !s_reg.busy && req.mreq && (sel_now.main_ram || req.rfsh);

  mpdp_dram_seq u_seq (
    .mclk(mclk),
    .rst(rst),
    .start(start),
    .refresh(req.rfsh),
    .addr(req.addr),
    .dram_addr(seq_addr),
    .ras_n(seq_ras_n),
    .cas_n(seq_cas_n),
    .col_phase(seq_col),
    .done(seq_done)
  );

  // Parity mismatch on the nine stored bits
  assign rd_err = mpdp_parity(dram_dq_in[7:0]) != dram_dq_in[8];

  // Control registers, access tracking, parity and outputs
  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.sel = sel_now;
    if (io_wr && io_addr == MPDP_PORT_PAGE) begin
      s_next.page = io_wdata[1:0];
    end
    if (io_wr && io_addr == MPDP_PORT_CTRL) begin
      s_next.rom = io_wdata[MPDP_CTRL_ROM_BIT];
      s_next.link = io_wdata[MPDP_CTRL_LINK_BIT];
      s_next.cs128 = io_wdata[MPDP_CTRL_CS128_BIT];
      s_next.badpar = io_wdata[MPDP_CTRL_BADPAR_BIT];
    end
    if (start) begin
      s_next.busy = 1'b1;
      s_next.is_wr = req.wr && !req.rfsh;
      s_next.is_rd_cpu = req.rd && !req.rfsh && !(dma_active && s_reg.link);
      s_next.is_rfsh = req.rfsh;
      s_next.dram.dq_out[7:0] = req.wdata;
      s_next.dram.dq_out[8] = mpdp_parity(req.wdata) ^ s_reg.badpar;
    end
    s_next.dram.addr = seq_addr;
    s_next.dram.ras_n = seq_ras_n;
    s_next.dram.cas_n = seq_cas_n;
    s_next.dram.we_n = !(s_reg.is_wr && seq_col);
    s_next.dram.dq_oe = s_reg.is_wr && seq_col && !s_reg.is_rfsh;
    if (seq_done) begin
      s_next.busy = 1'b0;
      if (!s_reg.is_wr && !s_reg.is_rfsh) begin
        s_next.rdata = dram_dq_in[7:0];
        s_next.rvalid = 1'b1;
      end
      if (s_reg.is_rd_cpu && rd_err) begin
        s_next.nmi = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.page <= MPDP_PAGE_RST;
      s_reg.rom <= MPDP_ROM_RST;
      s_reg.link <= MPDP_LINK_RST;
      s_reg.dram.ras_n <= 1'b1;
      s_reg.dram.cas_n <= 1'b1;
      s_reg.dram.we_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state
  assign dram = s_reg.dram;
  assign mem_sel = s_reg.sel;
  assign rdata = s_reg.rdata;
  assign rdata_valid = s_reg.rvalid;
  assign nmi = s_reg.nmi;
  assign link_enable = s_reg.link;
  assign page_out = s_reg.page;
  assign small_charset_select = s_reg.cs128;
  assign diag_rom_select = s_reg.rom;
endmodule // mpdp_top

// [mpdp_assertions.sv]
`timescale 1ns/1ps
module mpdp_assertions import mpdp_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire mpdp_pkg::mpdp_req_t cpu_req,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire mpdp_pkg::mpdp_req_t dma_req,
  input wire logic dma_active,
  input wire logic [8:0] dram_dq_in,
  input wire mpdp_pkg::mpdp_dram_t dram,
  input wire mpdp_pkg::mpdp_sel_t mem_sel,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid,
  input wire logic nmi,
  input wire logic link_enable,
  input wire logic [1:0] page_out,
  input wire logic small_charset_select,
  input wire logic diag_rom_select
);
  logic bad_reg;
  // Mirror of the forced bad parity control bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) bad_reg <= 1'b0;
    else if (io_wr && io_addr == MPDP_PORT_CTRL) bad_reg <= io_wdata[MPDP_CTRL_BADPAR_BIT];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_row; dram.cas_n [*2]; endsequence
  sequence s_col; (!dram.cas_n && !dram.ras_n) [*3] ##1 (dram.cas_n && dram.ras_n); endsequence
  property p_page; io_wr && io_addr == MPDP_PORT_PAGE |=> page_out == $past(io_wdata[1:0]);
  endproperty
  a_page: assert property (p_page) else $error("page register not loaded");
  property p_row; $fell(dram.ras_n) |-> s_row; endproperty
  a_row: assert property (p_row) else $error("row phase too short");
  property p_col; $fell(dram.cas_n) |-> s_col; endproperty
  a_col: assert property (p_col) else $error("column phase wrong");
  property p_par; dram.dq_oe |-> dram.dq_out[8] == (^dram.dq_out[7:0] ^ bad_reg); endproperty
  a_par: assert property (p_par) else $error("stored parity wrong");
  property p_nmi; nmi |=> nmi; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi dropped");
  property p_nmi_src; $rose(nmi) |-> rdata_valid; endproperty
  a_nmi_src: assert property (p_nmi_src) else $error("nmi without read");
  property p_one; $onehot0(mem_sel); endproperty
  a_one: assert property (p_one) else $error("several memories enabled");
  property p_idle; !cpu_req.mreq && !dma_req.mreq |=> mem_sel == '0; endproperty
  a_idle: assert property (p_idle) else $error("enable without request");
  property p_char;
    page_out == 2'h0 && cpu_req.mreq && !dma_active && cpu_req.addr[15:13] == 3'h7
      && !cpu_req.rfsh |=> mem_sel.char_ram;
  endproperty
  a_char: assert property (p_char) else $error("character ram not enabled");
  property p_wblk;
    diag_rom_select && cpu_req.mreq && cpu_req.wr && !dma_active
      && cpu_req.addr[15:12] == 4'h0 |=> !mem_sel.main_ram;
  endproperty
  a_wblk: assert property (p_wblk) else $error("low write not blocked");
  property p_dq; dram.dq_oe |-> !dram.we_n && !dram.cas_n; endproperty
  a_dq: assert property (p_dq) else $error("data driven outside column");
endmodule // mpdp_assertions

// [mpdp_dram_model.sv]
`timescale 1ns/1ps
module mpdp_dram_model import mpdp_pkg::*; (
  input wire logic mclk,
  input wire mpdp_pkg::mpdp_dram_t dram,
  output logic [8:0] dq_in
);
  logic [8:0] m [0:65535];
  logic [7:0] row;
  logic ras_q = 1'b1;
  logic cas_q = 1'b1;
  logic [8:0] last = 9'h000;
  // Cleared array keeps parity consistent on unwritten words
  initial for (int i = 0; i < 65536; i++) m[i] = 9'h000;
  // Row on strobe fall, column write on column strobe fall
  always @(posedge mclk) begin
    if (!dram.ras_n && ras_q) row = dram.addr;
    if (!dram.cas_n && cas_q && !dram.we_n && dram.dq_oe) m[{row, dram.addr}] = dram.dq_out;
    if (!dram.cas_n) last = dq_in;
    ras_q = dram.ras_n;
    cas_q = dram.cas_n;
  end
  // Data shown only during a read column phase, else a changed value
  assign dq_in = (!dram.cas_n && dram.we_n) ? m[{row, dram.addr}] : ~last;
endmodule // mpdp_dram_model

// [mpdp_top_tb.sv]
`timescale 1ns/1ps
module mpdp_top_tb;
  import mpdp_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  mpdp_req_t cpu_req = '0;
  mpdp_req_t dma_req = '0;
  logic [7:0] io_addr = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic io_wr = 1'b0;
  logic dma_active = 1'b0;
  logic [8:0] dram_dq_in;
  mpdp_dram_t dram;
  mpdp_sel_t mem_sel;
  mpdp_sel_t sel_q;
  mpdp_sel_t mem_sel_r;
  mpdp_sel_t sel_rq;
  logic [7:0] rdata, rd_q;
  logic rdata_valid, nmi, link_enable, small_charset_select, diag_rom_select, seen;
  logic [1:0] page_out;
  logic [24:0] tbl [10];
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  always #4 mclk = ~mclk;
  mpdp_top dut (.mclk(mclk), .rst(rst), .cpu_req(cpu_req), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .dma_req(dma_req), .dma_active(dma_active),
    .dram_dq_in(dram_dq_in), .dram(dram), .mem_sel(mem_sel), .rdata(rdata),
    .rdata_valid(rdata_valid), .nmi(nmi), .link_enable(link_enable), .page_out(page_out),
    .small_charset_select(small_charset_select), .diag_rom_select(diag_rom_select));
  mpdp_dram_model mem (.mclk(mclk), .dram(dram), .dq_in(dram_dq_in));
  // Reduced-memory build, watched on its block enables only
  mpdp_top #(.REDUCED_MEM(1'b1)) dut_small (.mclk(mclk), .rst(rst), .cpu_req(cpu_req),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .dma_req(dma_req),
    .dma_active(dma_active), .dram_dq_in(dram_dq_in), .dram(), .mem_sel(mem_sel_r),
    .rdata(), .rdata_valid(), .nmi(), .link_enable(), .page_out(), .small_charset_select(),
    .diag_rom_select());
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic io_out(input logic [7:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge mclk) #1 io_wr = 1'b0;
    @(posedge mclk) #1;
  endtask
  // One access by either master, held until its strobe cycle ends
  task automatic acc(input bit dma, input logic [15:0] a, input logic wr, input logic [7:0] d,
    input int n);
    mpdp_req_t r;
    r = '0;
    r.addr = a;
    r.wdata = d;
    r.mreq = 1'b1;
    r.rd = !wr;
    r.wr = wr;
    seen = 1'b0;
    if (dma) dma_req = r;
    else cpu_req = r;
    @(posedge mclk) #1;
    sel_q = mem_sel;
    sel_rq = mem_sel_r;
    for (int i = 0; i < n; i++) begin
      if (dram.cas_n === 1'b0) seen = 1'b1;
      if (wr ? (seen && dram.cas_n === 1'b1) : (rdata_valid === 1'b1)) break;
      @(posedge mclk) #1;
    end
    rd_q = rdata;
    cpu_req = '0;
    dma_req = '0;
    @(posedge mclk) #1;
  endtask
  task automatic print_verdict;
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Cycle ceiling against a hang
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      print_verdict;
    end
  end
  initial begin
    tbl = '{{2'd0, 1'b0, 16'hE000, 6'h08}, {2'd0, 1'b0, 16'hC000, 6'h04},
      {2'd2, 1'b0, 16'hC000, 6'h02}, {2'd2, 1'b0, 16'hD000, 6'h01},
      {2'd2, 1'b1, 16'hC800, 6'h00}, {2'd2, 1'b1, 16'hD800, 6'h00},
      {2'd2, 1'b1, 16'hC400, 6'h02}, {2'd2, 1'b1, 16'hD400, 6'h01},
      {2'd1, 1'b0, 16'hC000, 6'h20}, {2'd0, 1'b0, 16'h8000, 6'h20}};
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    @(posedge mclk) #1;
    chk(diag_rom_select, 1);
    chk({page_out, link_enable, nmi}, 0);
    acc(0, 16'h0100, 0, 8'h00, 2);
    chk(sel_q, 16'h10);
    $display("reset and rom test done");
    io_out(MPDP_PORT_CTRL, 8'h02);
    chk({diag_rom_select, link_enable}, 1);
    acc(0, 16'h0100, 1, 8'hA5, 12);
    acc(0, 16'h0100, 0, 8'h00, 12);
    chk(sel_q, 16'h20);
    chk(sel_rq, 16'h20);
    chk(rd_q, 8'hA5);
    chk(mem.m[16'h0100], 9'h0A5);
    io_out(MPDP_PORT_CTRL, 8'h03);
    acc(0, 16'h0100, 1, 8'h5A, 6);
    chk(sel_q, 0);
    io_out(MPDP_PORT_CTRL, 8'h02);
    acc(0, 16'h0100, 0, 8'h00, 12);
    chk(rd_q, 8'hA5);
    dma_active = 1'b1;
    acc(1, 16'h3000, 1, 8'h3C, 12);
    acc(1, 16'h3000, 0, 8'h00, 12);
    chk(rd_q, 8'h3C);
    dma_active = 1'b0;
    $display("main ram and link test done");
    cpu_req.mreq = 1'b1;
    cpu_req.rfsh = 1'b1;
    cpu_req.fetch = 1'b1;
    seen = 1'b0;
    rd_q = 8'h00;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk) #1;
      if (dram.ras_n === 1'b0) rd_q[0] = 1'b1;
      if (dram.cas_n !== 1'b1 || dram.dq_oe !== 1'b0) seen = 1'b1;
      if (mem_sel !== 6'h00) rd_q[1] = 1'b1;
    end
    cpu_req = '0;
    @(posedge mclk) #1;
    chk({rd_q[1:0], seen}, 16'h2);
    $display("refresh test done");
    for (int k = 0; k < 10; k++) begin
      io_out(MPDP_PORT_PAGE, {6'h00, tbl[k][24:23]});
      chk(page_out, tbl[k][24:23]);
      io_out(MPDP_PORT_CTRL, {5'h00, tbl[k][22], 2'h2});
      chk(small_charset_select, tbl[k][22]);
      acc(0, tbl[k][21:6], 0, 8'h00, tbl[k][5] ? 12 : 2);
      chk(sel_q, tbl[k][5:0]);
      chk(sel_rq, tbl[k][5:0] & {!tbl[k][21], 5'h1F});
    end
    chk(nmi, 0);
    $display("decode test done");
    io_out(MPDP_PORT_CTRL, 8'h0A);
    acc(0, 16'h2000, 1, 8'h11, 12);
    io_out(MPDP_PORT_CTRL, 8'h02);
    acc(0, 16'h2000, 0, 8'h00, 12);
    chk(nmi, 1);
    acc(0, 16'h0100, 0, 8'h00, 2);
    chk(sel_q, 16'h10);
    $display("parity test done");
    print_verdict;
  end
endmodule // mpdp_top_tb
bind mpdp_top mpdp_assertions chk_i (.*);
